// *** verilog/cpu_clock_params.svh ***
`ifndef CPU_CLOCK_PARAMS_SVH
`define CPU_CLOCK_PARAMS_SVH

// ----------------------------------------------------------------------
// Register location and reset value
// ----------------------------------------------------------------------
`define PCLK_CTRL_ADDR      16'hFFFB
`define PCLK_CTRL_RESET     8'h00

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define BIT_MAIN_OSC_STOP   7
`define BIT_FB_RES_OFF      6
`define BIT_SUB_STATUS      5
`define BIT_SUB_SELECT      4
`define BIT_ZERO3           3
`define DIV_MSB             2

// ----------------------------------------------------------------------
// Division codes and instruction timing
// ----------------------------------------------------------------------
`define DIV_CODE_1          3'h0
`define DIV_CODE_2          3'h1
`define DIV_CODE_4          3'h2
`define DIV_CODE_8          3'h3
`define DIV_CODE_16         3'h4
`define SUB_DIV_M1          4'h1
`define INSTR_MIN_CLOCKS    2

`endif

// *** verilog/cpu_clock_pkg.sv ***
`default_nettype none
package cpu_clock_pkg;

    // Source the CPU clock is taken from
    typedef enum logic [1:0] {
        SRC_RING,
        SRC_X1,
        SRC_SUB
    } clk_src_t;

    // One tick per cycle of each oscillator, sampled on core_clk
    typedef struct packed {
        logic x1;
        logic ring;
        logic sub;
    } osc_tick_t;

    // CPU memory access to the control register
    typedef struct packed {
        logic [15:0] addr;
        logic        wr_byte;
        logic        wr_bit;
        logic [2:0]  bit_idx;
        logic        bit_val;
        logic [7:0]  wdata;
        logic        rd;
    } mem_req_t;

endpackage
`default_nettype wire

// *** verilog/cpu_clock_select_divider.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "cpu_clock_params.svh"

module cpu_clock_select_divider
    import cpu_clock_pkg::*;
#(
    parameter bit RING_DIV2_OK = 1'b1
) (
    input  wire logic       core_clk,
    input  wire logic       rstn,
    input  wire mem_req_t   mem_req,
    input  wire osc_tick_t  osc_tick,
    input  wire logic       main_clock_select_bit,
    input  wire logic       x1_stop_alt_bit,
    output logic [7:0]      rd_data_ff,
    output logic            x1_stop_ff,
    output logic            feedback_resistor_off_ff,
    output logic            main_clock_status_bit_ff,
    output clk_src_t        cpu_src_ff,
    output logic            cpu_tick_ff,
    output logic            instr_tick_ff
);

    // Elaboration check: the grade switch is a single flag
    if (RING_DIV2_OK !== 1'b0 && RING_DIV2_OK !== 1'b1) begin : g_bad_grade
        $error("RING_DIV2_OK must be 0 or 1");
    end

    // ------------------------------------------------------------------
    // Divide ratio lookup
    // ------------------------------------------------------------------
    // Prohibited codes fall back to the undivided clock so the CPU never
    // stalls on a bad write; the subclock always runs at half rate.
    function automatic logic [3:0] ratio_m1(input clk_src_t src, input logic [2:0] code);
        logic [3:0] r;
        r = 4'h0;
        if (src == SRC_SUB) begin
            r = `SUB_DIV_M1;
        end else if (src == SRC_RING) begin
            if (code == `DIV_CODE_2 && RING_DIV2_OK) begin
                r = 4'h1;
            end
        end else begin
            case (code)
                `DIV_CODE_2:  r = 4'h1;
                `DIV_CODE_4:  r = 4'h3;
                `DIV_CODE_8:  r = 4'h7;
                `DIV_CODE_16: r = 4'hF;
                default:      r = 4'h0;
            endcase
        end
        return r;
    endfunction

    function automatic logic src_tick(input clk_src_t src, input osc_tick_t t);
        logic v;
        v = 1'b0;
        case (src)
            SRC_RING: v = t.ring;
            SRC_X1:   v = t.x1;
            SRC_SUB:  v = t.sub;
            default:  v = 1'b0;
        endcase
        return v;
    endfunction

    // ------------------------------------------------------------------
    // Control register storage
    // ------------------------------------------------------------------
    typedef enum logic {
        SW_RUN,
        SW_WAIT
    } sw_state_t;

    logic       main_osc_stop_bit_ff;
    logic       feedback_resistor_off_bit_ff;
    logic       subclock_select_ff;
    logic [2:0] divider_sel_ff;
    logic       subclock_status_ff;
    sw_state_t  sw_state_ff;
    logic [3:0] div_cnt_ff;
    logic       instr_phase_ff;

    wire logic       hit        = (mem_req.addr == `PCLK_CTRL_ADDR);
    wire logic       byte_wr    = hit & mem_req.wr_byte;
    wire logic       bit_wr     = hit & mem_req.wr_bit & ~mem_req.wr_byte;
    wire logic [7:0] cur_view   = {main_osc_stop_bit_ff, feedback_resistor_off_bit_ff,
                                   subclock_status_ff, subclock_select_ff, 1'b0,
                                   divider_sel_ff};

    // Bit write is a read-modify-write of the current view
    logic [7:0] bit_merge;
    always_comb begin
        bit_merge = cur_view;
        bit_merge[mem_req.bit_idx] = mem_req.bit_val;
    end

    wire logic [7:0] wr_val     = byte_wr ? mem_req.wdata : bit_merge;
    wire logic       any_wr     = byte_wr | bit_wr;

    // Bit 5 and bit 3 are not stored; bit 3 always reads zero
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            main_osc_stop_bit_ff         <= 1'b0;
            feedback_resistor_off_bit_ff <= 1'b0;
            subclock_select_ff           <= 1'b0;
            divider_sel_ff               <= 3'h0;
        end else if (any_wr) begin
            main_osc_stop_bit_ff         <= wr_val[`BIT_MAIN_OSC_STOP];
            feedback_resistor_off_bit_ff <= wr_val[`BIT_FB_RES_OFF];
            subclock_select_ff           <= wr_val[`BIT_SUB_SELECT];
            divider_sel_ff               <= wr_val[`DIV_MSB:0];
        end
    end

    // Read data is registered; unaddressed reads return zero
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            rd_data_ff <= 8'h00;
        end else begin
            rd_data_ff <= (hit & mem_req.rd) ? cur_view : 8'h00;
        end
    end

    // ------------------------------------------------------------------
    // Source selection and glitch-free switch
    // ------------------------------------------------------------------
    // The main select picks ring or X1; the subclock select overrides.
    // Leaving the subclock is only safe once X1 is already running;
    // the hardware does not police that, software must.
    wire clk_src_t   want_src   = subclock_select_ff ? SRC_SUB :
                                  (main_clock_select_bit ? SRC_X1 : SRC_RING);
    wire logic       new_tick   = src_tick(want_src, osc_tick);
    wire logic       cur_tick   = src_tick(cpu_src_ff, osc_tick);
    wire logic [3:0] ratio      = ratio_m1(cpu_src_ff, divider_sel_ff);
    wire logic       div_wrap   = cur_tick & (div_cnt_ff >= ratio);
    wire logic       switch_now = (sw_state_ff == SW_WAIT) & new_tick;

    // Wait for the old divided clock to finish a period, then for the
    // first tick of the new source, so no runt CPU pulse is produced.
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            sw_state_ff <= SW_RUN;
            cpu_src_ff  <= SRC_RING;
        end else begin
            case (sw_state_ff)
                SW_RUN: begin
                    if (want_src != cpu_src_ff && (div_wrap || div_cnt_ff == 4'h0)) begin
                        sw_state_ff <= SW_WAIT;
                    end
                end
                SW_WAIT: begin
                    if (want_src == cpu_src_ff) begin
                        sw_state_ff <= SW_RUN;
                    end else if (new_tick) begin
                        cpu_src_ff  <= want_src;
                        sw_state_ff <= SW_RUN;
                    end
                end
                default: sw_state_ff <= SW_RUN;
            endcase
        end
    end

    // Status bits follow the source actually driving the CPU. While on
    // the subclock the main status follows the main select, so software
    // can see X1 ready before it leaves the subclock.
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            subclock_status_ff       <= 1'b0;
            main_clock_status_bit_ff <= 1'b0;
        end else begin
            subclock_status_ff       <= (cpu_src_ff == SRC_SUB);
            main_clock_status_bit_ff <= (cpu_src_ff == SRC_X1)
                                      | ((cpu_src_ff == SRC_SUB) & main_clock_select_bit);
        end
    end

    // ------------------------------------------------------------------
    // Divider and instruction pacing
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rstn || switch_now) begin
            div_cnt_ff  <= 4'h0;
            cpu_tick_ff <= 1'b0;
        end else begin
            cpu_tick_ff <= div_wrap;
            if (div_wrap) begin
                div_cnt_ff <= 4'h0;
            end else if (cur_tick) begin
                div_cnt_ff <= div_cnt_ff + 4'h1;
            end
        end
    end

    // One instruction slot every second CPU clock
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            instr_phase_ff <= 1'b0;
            instr_tick_ff  <= 1'b0;
        end else begin
            instr_tick_ff <= cpu_tick_ff & instr_phase_ff;
            if (cpu_tick_ff) begin
                instr_phase_ff <= ~instr_phase_ff;
            end
        end
    end

    // ------------------------------------------------------------------
    // Oscillator controls
    // ------------------------------------------------------------------
    // On the ring clock only the alternate stop bit acts; on the
    // subclock only bit 7 acts; on X1 neither may stop its own clock.
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            x1_stop_ff               <= 1'b0;
            feedback_resistor_off_ff <= 1'b0;
        end else begin
            x1_stop_ff <= ((cpu_src_ff == SRC_SUB) & main_osc_stop_bit_ff)
                        | ((cpu_src_ff == SRC_RING) & x1_stop_alt_bit);
            feedback_resistor_off_ff <= feedback_resistor_off_bit_ff;
        end
    end

endmodule
`default_nettype wire

// *** sim/cpu_clock_select_divider_asserts.sv ***
`timescale 1ns/10ps
`default_nettype none
module cpu_clock_select_divider_asserts
    import cpu_clock_pkg::*;
(
    input wire logic       core_clk,
    input wire logic       rstn,
    input wire mem_req_t   mem_req,
    input wire osc_tick_t  osc_tick,
    input wire logic       main_clock_select_bit,
    input wire logic       x1_stop_alt_bit,
    input wire logic [7:0] rd_data_ff,
    input wire logic       x1_stop_ff,
    input wire logic       feedback_resistor_off_ff,
    input wire logic       main_clock_status_bit_ff,
    input wire clk_src_t   cpu_src_ff,
    input wire logic       cpu_tick_ff,
    input wire logic       instr_tick_ff
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    logic rd_hit;
    // Read strobe aimed at the control register
    assign rd_hit = mem_req.rd && mem_req.addr == 16'hfffb;
    // Reset check must run while reset is low, so it opts out of the disable
    property p_rst;
        disable iff (1'b0) !rstn |=> rd_data_ff == 8'h00 && cpu_src_ff == SRC_RING && !x1_stop_ff;
    endproperty
    property p_rd0; !$past(rd_hit) |-> rd_data_ff == 8'h00; endproperty
    property p_b3; $past(rd_hit) |-> !rd_data_ff[3]; endproperty
    property p_fb;
        mem_req.wr_byte && mem_req.addr == 16'hfffb |-> ##2
            feedback_resistor_off_ff == $past(mem_req.wdata[6], 2);
    endproperty
    property p_x1; cpu_src_ff == SRC_X1 && $past(cpu_src_ff) == SRC_X1 |-> !x1_stop_ff; endproperty
    property p_ring;
        cpu_src_ff == SRC_RING && $past(cpu_src_ff) == SRC_RING && !x1_stop_alt_bit
            && !$past(x1_stop_alt_bit) |-> !x1_stop_ff;
    endproperty
    property p_mst; $rose(cpu_src_ff == SRC_X1) |-> ##[0:1] main_clock_status_bit_ff; endproperty
    property p_ins; instr_tick_ff |-> $past(cpu_tick_ff); endproperty
    property p_sub;
        cpu_tick_ff && cpu_src_ff == SRC_SUB && $past(cpu_src_ff) == SRC_SUB |-> $past(osc_tick.sub);
    endproperty
    a_rst: assert property (p_rst) else $error("reset values wrong");
    a_rd0: assert property (p_rd0) else $error("read data without read");
    a_b3: assert property (p_b3) else $error("bit 3 read nonzero");
    a_fb: assert property (p_fb) else $error("feedback select not stored");
    a_x1: assert property (p_x1) else $error("X1 stopped while running on it");
    a_ring: assert property (p_ring) else $error("bit 7 stopped X1 on ring");
    a_mst: assert property (p_mst) else $error("main status late");
    a_ins: assert property (p_ins) else $error("instr tick without cpu tick");
    a_sub: assert property (p_sub) else $error("sub tick missing");
    c_sub: cover property (cpu_src_ff == SRC_SUB);
    c_ins: cover property (instr_tick_ff);
    c_stop: cover property (x1_stop_ff);
endmodule
bind cpu_clock_select_divider cpu_clock_select_divider_asserts i_chk (.core_clk, .rstn,
    .mem_req, .osc_tick, .main_clock_select_bit, .x1_stop_alt_bit, .rd_data_ff, .x1_stop_ff,
    .feedback_resistor_off_ff, .main_clock_status_bit_ff, .cpu_src_ff, .cpu_tick_ff,
    .instr_tick_ff);
`default_nettype wire

// *** sim/tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import cpu_clock_pkg::*;
;
    logic       core_clk = 1'b0;
    logic       rstn;
    mem_req_t   mem_req;
    osc_tick_t  osc_tick = '0;
    logic       main_clock_select_bit;
    logic       x1_stop_alt_bit;
    logic [7:0] rd_data_ff;
    logic       x1_stop_ff;
    logic       feedback_resistor_off_ff;
    logic       main_clock_status_bit_ff;
    clk_src_t   cpu_src_ff;
    logic       cpu_tick_ff;
    logic       instr_tick_ff;
    int         errors = 0;
    int         checked = 0;
    int         cyc = 0;
    logic [7:0] ring_exp [3] = '{8'h03, 8'h06, 8'h03};
    cpu_clock_select_divider i_dut (.core_clk, .rstn, .mem_req, .osc_tick,
        .main_clock_select_bit, .x1_stop_alt_bit, .rd_data_ff, .x1_stop_ff,
        .feedback_resistor_off_ff, .main_clock_status_bit_ff, .cpu_src_ff, .cpu_tick_ff,
        .instr_tick_ff);
    // ------------------------------------------------------------
    // Clock and oscillator ticks
    // ------------------------------------------------------------
    always #25 core_clk = ~core_clk;
    // Coprime tick spacings so a wrong source shows up as a wrong period
    always @(negedge core_clk) begin
        cyc <= cyc + 1;
        osc_tick <= '{cyc % 2 == 0, cyc % 3 == 0, cyc % 5 == 0};
    end
    // ------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checked++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    // One request cycle; read data is registered by the taking edge
    task automatic go(input mem_req_t r);
        @(negedge core_clk);
        mem_req = r;
        @(negedge core_clk);
        mem_req = '0;
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        go('{a, 1'b1, 1'b0, 3'h0, 1'b0, d, 1'b0});
    endtask
    task automatic wb(input logic [2:0] i, input logic v);
        go('{16'hfffb, 1'b0, 1'b1, i, v, 8'h00, 1'b0});
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        go('{a, 1'b0, 1'b0, 3'h0, 1'b0, 8'h00, 1'b1});
        chk(rd_data_ff, e);
    endtask
    // Third interval only: the first two may straddle a ratio change
    task automatic per(input logic [7:0] e);
        logic [7:0] n;
        repeat (3) begin
            n = 8'h00;
            do begin
                @(negedge core_clk);
                n++;
            end while (cpu_tick_ff !== 1'b1 && n < 8'h80);
        end
        chk(n, e);
    endtask
    // Instruction slots come every second CPU clock
    task automatic iper(input logic [7:0] e);
        logic [7:0] n;
        repeat (3) begin
            n = 8'h00;
            do begin
                @(negedge core_clk);
                n++;
            end while (instr_tick_ff !== 1'b1 && n < 8'h80);
        end
        chk(n, e);
    endtask
    task automatic wsrc(input clk_src_t s);
        repeat (200) if (cpu_src_ff !== s) @(negedge core_clk);
        repeat (2) @(negedge core_clk);
        chk(8'(cpu_src_ff), 8'(s));
    endtask
    task automatic print_verdict;
        $display("errors=%0d checked=%0d", errors, checked);
        if (errors == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Watchdog at 10000 cycles, well beyond the few hundred cycles the run needs
    initial begin
        #500000;
        errors++;
        print_verdict;
    end
    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        rstn = 1'b0;
        mem_req = '0;
        main_clock_select_bit = 1'b0;
        x1_stop_alt_bit = 1'b0;
        repeat (10) @(negedge core_clk);
        rstn = 1'b1;
        rd(16'hfffb, 8'h00);
        wr(16'hfffb, 8'h4c);
        rd(16'hfffb, 8'h44);
        chk(feedback_resistor_off_ff, 1'b1);
        per(8'h03);
        wr(16'hfffa, 8'h00);
        rd(16'hfffb, 8'h44);
        rd(16'hfffa, 8'h00);
        foreach (ring_exp[k]) begin
            wr(16'hfffb, {5'h00, 3'(k)});
            per(ring_exp[k]);
        end
        wr(16'hfffb, 8'h80);
        repeat (3) @(negedge core_clk);
        chk(x1_stop_ff, 1'b0);
        x1_stop_alt_bit = 1'b1;
        repeat (3) @(negedge core_clk);
        chk(x1_stop_ff, 1'b1);
        x1_stop_alt_bit = 1'b0;
        main_clock_select_bit = 1'b1;
        wsrc(SRC_X1);
        chk(main_clock_status_bit_ff, 1'b1);
        chk(x1_stop_ff, 1'b0);
        for (int k = 0; k < 5; k++) begin
            wr(16'hfffb, {5'h10, 3'(k)});
            per(8'h02 << k);
        end
        wr(16'hfffb, 8'h80);
        wb(3'h4, 1'b1);
        wsrc(SRC_SUB);
        per(8'h0a);
        iper(8'h14);
        rd(16'hfffb, 8'hb0);
        chk(x1_stop_ff, 1'b1);
        wb(3'h7, 1'b0);
        repeat (3) @(negedge core_clk);
        chk(x1_stop_ff, 1'b0);
        chk(main_clock_status_bit_ff, 1'b1);
        wb(3'h4, 1'b0);
        wsrc(SRC_X1);
        rd(16'hfffb, 8'h00);
        wr(16'hfffb, 8'h44);
        main_clock_select_bit = 1'b0;
        rstn = 1'b0;
        repeat (10) @(negedge core_clk);
        rstn = 1'b1;
        rd(16'hfffb, 8'h00);
        chk(feedback_resistor_off_ff, 1'b0);
        print_verdict;
    end
endmodule
`default_nettype wire
